// File: core/pdw_pkg.sv
// Package: constants for the power-down, wake-up and watchdog block.
// Assumes one 10 MHz system clock and an AXI4-Lite register bus.
package pdw_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_PRESCALE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_USB_CLK = 8'h0C;
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int PS_LSB = 0;
  localparam int PS_W = 3;
  localparam logic [2:0] PS_RESET = 3'h7;
  localparam int ST_PDF_BIT = 0;
  localparam int ST_TO_BIT = 1;
  localparam int ST_HALT_BIT = 2;
  localparam int CFG_WDT_EN_BIT = 0;
  localparam int CFG_WDT_SRC_BIT = 1;
  localparam int CFG_DUAL_CLR_BIT = 2;
  localparam logic [2:0] CFG_RESET = 3'h1;
  localparam int USB_SYSTEM_CLOCK_RATE_SELECT_BIT = 0;
  localparam logic USB_SYSTEM_CLOCK_RATE_SELECT_RESET = 1'b0;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int WAKE_DELAY_CYC = 1024;
  localparam int INSTR_DIV = 4;
  localparam int WDT_OSC_DIV = 256;
  localparam int WDT_BASE_BITS = 8;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_HALT,
    MODE_WAKE
  } mode_t;
endpackage

// File: core/power_down_wakeup_watchdog.sv
// Power-down, wake-up delay and watchdog for a small processor core.
// Assumes the core pulses its instruction strobes for one system clock.
// Functional notes
// R1: Only the halt instruction enters power-down
// R2: Power-down stops oscillator, holds execution
// R3: Halt clears watchdog; keeps running only on own oscillator
// R4: Halt sets power-down flag, clears time-out flag
// R5: Wake on reset, pin edge, interrupt, watchdog
// R6: Reset pin full reset; watchdog wake partial
// R7: Power-down flag cleared by power-up, watchdog clear
// R8: Time-out sets flag; others kept in power-down
// R9: Enabled pins wake on falling edge, resume
// R10: Disabled interrupt or full stack resumes after halt
// R11: Enabled interrupt with free stack gets serviced
// R12: Interrupts already pending cannot wake device
// R13: Wait 1024 system clocks after any wake
// R14: Interrupt entry at least one cycle later
// R15: Watchdog overflow generates device reset
// R16: Watchdog clock: own oscillator or system clock/4
// R17: Disabled watchdog makes its instructions no-ops
// R18: Own oscillator divided by 256 first
// R19: Prescale bits 0-2, all ones is 1:128
// R20: Firmware sets USB system clock select bit
// R21: Prescale ratio is two to the field value
// R22: Time-out in power-down leaves both flags one
// R23: Pin reset, clear instructions, halt clear watchdog
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module power_down_wakeup_watchdog
  import pdw_pkg::*;
#(
  parameter int PIN_W = 24,
  parameter int IRQ_W = 4,
  parameter int WAKE_CYC = WAKE_DELAY_CYC
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic rst_pin_n_i,
  input wire logic wdt_osc_i,
  input wire logic [PIN_W-1:0] pin_i,
  input wire logic [PIN_W-1:0] pin_wake_en_i,
  input wire logic [IRQ_W-1:0] irq_req_i,
  input wire logic [IRQ_W-1:0] irq_en_i,
  input wire logic stack_full_i,
  input wire logic halt_instr_i,
  input wire logic watchdog_clear_instruction_i,
  input wire logic clr_wdt1_i,
  input wire logic clr_wdt2_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic osc_run_o,
  output logic cpu_hold_o,
  output logic full_reset_o,
  output logic wdt_reset_o,
  output logic irq_service_o,
  output logic usb_system_clock_rate_select_sel_o
);
  initial begin
    if (PIN_W < 1 || IRQ_W < 1 || WAKE_CYC < 2) begin
      $error("power_down_wakeup_watchdog: bad parameter");
    end
  end

  localparam int WCNT_W = $clog2(WAKE_CYC + 1);
  localparam int WDT_W = WDT_BASE_BITS + 8;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    mode_t mode;
    logic [WCNT_W-1:0] wake_cnt;
    logic wake_irq;
    logic wake_wdt;
    logic [1:0] rst_sync;
    logic [1:0] osc_sync;
    logic osc_last;
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [PIN_W-1:0] pin_last;
    logic [IRQ_W-1:0] irq_armed;
    logic [1:0] instr_div;
    logic [WDT_BASE_BITS-1:0] base;
    logic [7:0] presc;
    logic [2:0] ps_sel;
    logic [2:0] cfg;
    logic usb_system_clock_rate_select;
    logic power_down_flag;
    logic tof;
    logic clr1_seen;
    logic clr2_seen;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic osc_run;
    logic cpu_hold;
    logic full_reset;
    logic wdt_reset;
    logic irq_service;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic addr_ok(input logic [7:0] a);
    return a == ADDR_PRESCALE || a == ADDR_STATUS || a == ADDR_CONFIG || a == ADDR_USB_CLK;
  endfunction

  // R21: Two to the field
  function automatic logic presc_tick(input logic [7:0] p, input logic [2:0] sel);
    logic [7:0] m;
    m = 8'hFF >> (4'h8 - {1'b0, sel});
    return (p & m) == m;
  endfunction

  logic wdt_en;
  logic wdt_own;
  logic wdt_clr;
  logic wdt_tick;
  logic base_tick;
  logic overflow;
  logic pin_fall;
  logic irq_wake;
  logic halt_ok;

  always_comb begin
    s_d = s_q;
    wdt_en = s_q.cfg[CFG_WDT_EN_BIT];
    wdt_own = ~s_q.cfg[CFG_WDT_SRC_BIT];
    s_d.full_reset = 1'b0;
    s_d.wdt_reset = 1'b0;
    s_d.irq_service = 1'b0;

    // Synchronisers for pins, reset pin and watchdog oscillator
    s_d.rst_sync = {s_q.rst_sync[0], rst_pin_n_i};
    s_d.osc_sync = {s_q.osc_sync[0], wdt_osc_i};
    s_d.osc_last = s_q.osc_sync[1];
    s_d.pin_s1 = pin_i;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.pin_last = s_q.pin_s2;

    // R1: Halt only entry
    halt_ok = halt_instr_i && s_q.mode == MODE_RUN;

    // R17: Disabled watchdog ignores instructions
    wdt_clr = 1'b0;
    if (wdt_en && s_q.mode == MODE_RUN) begin
      if (s_q.cfg[CFG_DUAL_CLR_BIT]) begin
        if (clr_wdt1_i && !s_q.clr1_seen) begin
          s_d.clr1_seen = 1'b1;
        end
        if (clr_wdt2_i && !s_q.clr2_seen) begin
          s_d.clr2_seen = 1'b1;
        end
        if ((s_q.clr1_seen || clr_wdt1_i) && (s_q.clr2_seen || clr_wdt2_i)) begin
          wdt_clr = 1'b1;
          s_d.clr1_seen = 1'b0;
          s_d.clr2_seen = 1'b0;
        end
      end else begin
        wdt_clr = watchdog_clear_instruction_i;
      end
    end

    // R16: Clock source select
    s_d.instr_div = s_q.instr_div + 2'h1;
    if (wdt_own) begin
      wdt_tick = s_q.osc_sync[1] && !s_q.osc_last;
    end else begin
      // R3: Stops with system clock
      wdt_tick = s_q.instr_div == 2'(INSTR_DIV - 1) && s_q.mode == MODE_RUN;
    end
    // R18: Fixed divide by 256
    base_tick = 1'b0;
    if (wdt_en && wdt_tick) begin
      s_d.base = s_q.base + 1'b1;
      base_tick = s_q.base == 8'(WDT_OSC_DIV - 1);
    end
    // R19: Prescaler ratio
    overflow = 1'b0;
    if (base_tick) begin
      s_d.presc = s_q.presc + 8'h01;
      overflow = presc_tick(s_q.presc, s_q.ps_sel);
      if (overflow) begin
        s_d.presc = 8'h00;
      end
    end
    // R23: Watchdog clear sources
    if (wdt_clr || halt_ok || !s_q.rst_sync[1]) begin
      s_d.base = '0;
      s_d.presc = '0;
    end

    // R9: Falling edges on enabled pins
    pin_fall = |(s_q.pin_last & ~s_q.pin_s2 & pin_wake_en_i);
    // R12: Only requests new since halt
    irq_wake = |(irq_req_i & s_q.irq_armed);

    // R7: Clear instructions clear power-down flag
    if (wdt_clr) begin
      s_d.power_down_flag = 1'b0;
      s_d.tof = 1'b0;
    end

    unique case (s_q.mode)
      MODE_RUN: begin
        if (halt_ok) begin
          // R2: Stop oscillator, hold core
          s_d.mode = MODE_HALT;
          s_d.osc_run = 1'b0;
          s_d.cpu_hold = 1'b1;
          // R4: Flags on halt
          s_d.power_down_flag = 1'b1;
          s_d.tof = 1'b0;
          s_d.irq_armed = ~irq_req_i;
        end else if (overflow) begin
          // R15: Overflow resets device
          s_d.full_reset = 1'b1;
          s_d.tof = 1'b1;
        end
      end
      MODE_HALT: begin
        // R5: Four wake sources
        if (!s_q.rst_sync[1]) begin
          // R6: Full reset on pin
          s_d.full_reset = 1'b1;
          s_d.power_down_flag = 1'b0;
          s_d.tof = 1'b0;
          s_d.mode = MODE_WAKE;
        end else if (overflow || pin_fall || irq_wake) begin
          s_d.mode = MODE_WAKE;
          s_d.wake_wdt = overflow;
          s_d.wake_irq = irq_wake && !overflow;
          // R8: Only time-out flag changes
          // R22: Both flags one
          s_d.tof = s_q.tof | overflow;
        end
        if (s_d.mode == MODE_WAKE) begin
          s_d.osc_run = 1'b1;
          s_d.wake_cnt = '0;
        end
      end
      MODE_WAKE: begin
        // R13: Fixed wake delay
        s_d.wake_cnt = s_q.wake_cnt + 1'b1;
        if (s_q.wake_cnt == WCNT_W'(WAKE_CYC - 1)) begin
          s_d.mode = MODE_RUN;
          s_d.cpu_hold = 1'b0;
          // R6: Partial reset on watchdog wake
          s_d.wdt_reset = s_q.wake_wdt;
          // R10: Disabled or full stack resumes
          // R11: Otherwise normal interrupt response
          // R14: Service one cycle after delay
          s_d.irq_service = s_q.wake_irq && |(irq_req_i & irq_en_i) && !stack_full_i;
          s_d.wake_irq = 1'b0;
          s_d.wake_wdt = 1'b0;
        end
      end
      default: s_d.mode = MODE_RUN;
    endcase

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    s_d.awready = 1'b0;
    s_d.wready = 1'b0;
    s_d.arready = 1'b0;
    if (s_q.awready && s_axi_awvalid_i) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr_i;
    end else if (!s_q.aw_got && !s_q.bvalid && s_axi_awvalid_i) begin
      s_d.awready = 1'b1;
    end
    if (s_q.wready && s_axi_wvalid_i) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata_i;
      s_d.wstrb = s_axi_wstrb_i;
    end else if (!s_q.w_got && !s_q.bvalid && s_axi_wvalid_i) begin
      s_d.wready = 1'b1;
    end
    if (s_q.aw_got && s_q.w_got) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = addr_ok(s_q.awaddr) ? AXI_OKAY : AXI_SLVERR;
      if (s_q.wstrb[0]) begin
        unique case (s_q.awaddr)
          ADDR_PRESCALE: s_d.ps_sel = s_q.wdata[PS_LSB +: PS_W];
          ADDR_CONFIG: s_d.cfg = s_q.wdata[2:0];
          // R20: Firmware chosen rate
          ADDR_USB_CLK: s_d.usb_system_clock_rate_select = s_q.wdata[USB_SYSTEM_CLOCK_RATE_SELECT_BIT];
          default: begin
          end
        endcase
      end
    end
    if (s_q.bvalid && s_axi_bready_i) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.arready && s_axi_arvalid_i) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = addr_ok(s_axi_araddr_i) ? AXI_OKAY : AXI_SLVERR;
      s_d.rdata = 32'h0000_0000;
      unique case (s_axi_araddr_i)
        ADDR_PRESCALE: s_d.rdata[PS_LSB +: PS_W] = s_q.ps_sel;
        ADDR_STATUS: begin
          s_d.rdata[ST_PDF_BIT] = s_q.power_down_flag;
          s_d.rdata[ST_TO_BIT] = s_q.tof;
          s_d.rdata[ST_HALT_BIT] = s_q.cpu_hold;
        end
        ADDR_CONFIG: s_d.rdata[2:0] = s_q.cfg;
        ADDR_USB_CLK: s_d.rdata[USB_SYSTEM_CLOCK_RATE_SELECT_BIT] = s_q.usb_system_clock_rate_select;
        default: begin
        end
      endcase
    end else if (!s_q.rvalid && s_axi_arvalid_i) begin
      s_d.arready = 1'b1;
    end
    if (s_q.rvalid && s_axi_rready_i) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
      s_q.mode <= MODE_RUN;
      s_q.rst_sync <= 2'h3;
      s_q.ps_sel <= PS_RESET;
      s_q.cfg <= CFG_RESET;
      s_q.usb_system_clock_rate_select <= USB_SYSTEM_CLOCK_RATE_SELECT_RESET;
      s_q.osc_run <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready_o = s_q.awready;
  assign s_axi_wready_o = s_q.wready;
  assign s_axi_bresp_o = s_q.bresp;
  assign s_axi_bvalid_o = s_q.bvalid;
  assign s_axi_arready_o = s_q.arready;
  assign s_axi_rdata_o = s_q.rdata;
  assign s_axi_rresp_o = s_q.rresp;
  assign s_axi_rvalid_o = s_q.rvalid;
  assign osc_run_o = s_q.osc_run;
  assign cpu_hold_o = s_q.cpu_hold;
  assign full_reset_o = s_q.full_reset;
  assign wdt_reset_o = s_q.wdt_reset;
  assign irq_service_o = s_q.irq_service;
  assign usb_system_clock_rate_select_sel_o = s_q.usb_system_clock_rate_select;
endmodule

// File: bench/pdw_chk_sva.sv
// Checker for the power-down, wake and watchdog block.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
module pdw_chk #(
  parameter int WAKE_CYC = 16
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic halt_instr_i,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_rready_i,
  input wire logic s_axi_bvalid_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic osc_run_o,
  input wire logic cpu_hold_o,
  input wire logic full_reset_o,
  input wire logic wdt_reset_o,
  input wire logic irq_service_o
);
  // ----------------------------------------
  // Wake delay counter
  // ----------------------------------------
  logic [11:0] cnt_q;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= 12'h000;
    end else begin
      cnt_q <= (osc_run_o && cpu_hold_o) ? cnt_q + 12'h001 : 12'h000;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // halt enters
  AST_HALT_ENTRY: assert property (halt_instr_i && !cpu_hold_o |=> cpu_hold_o && !osc_run_o)
    else $error("halt not entered");
  AST_ONLY_HALT: assert property ($rose(cpu_hold_o) |-> $past(halt_instr_i))
    else $error("hold without halt");
  AST_STOP_HELD: assert property (!osc_run_o |-> cpu_hold_o)
    else $error("oscillator off while running");
  AST_WAKE_IN_HALT: assert property ($rose(osc_run_o) |-> cpu_hold_o)
    else $error("wake outside halt");
  AST_WAKE_DELAY: assert property ($fell(cpu_hold_o) |-> cnt_q == WAKE_CYC)
    else $error("wake delay wrong");
  AST_WAKE_BOUND: assert property (cnt_q <= WAKE_CYC)
    else $error("wake delay overrun");
  AST_WDT_PULSE: assert property (wdt_reset_o |-> $fell(cpu_hold_o) && !irq_service_o)
    else $error("watchdog reset misplaced");
  AST_IRQ_PULSE: assert property (irq_service_o |-> $fell(cpu_hold_o))
    else $error("service misplaced");
  AST_RESET_PULSE: assert property (full_reset_o |=> !full_reset_o)
    else $error("reset pulse too long");
  AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
endmodule
bind power_down_wakeup_watchdog pdw_chk #(.WAKE_CYC(WAKE_CYC)) chk (.clk_sys_i, .sys_rst_i, .halt_instr_i,
  .s_axi_bready_i, .s_axi_rready_i, .s_axi_bvalid_o, .s_axi_bresp_o, .s_axi_rvalid_o, .s_axi_rdata_o,
  .osc_run_o, .cpu_hold_o, .full_reset_o, .wdt_reset_o, .irq_service_o);

// File: bench/core_model.sv
// Processor core model: issues halt and clear instructions.
// Assumes requests come from the bench, one cycle each.
`timescale 1ns/1ps
module core_model (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic cpu_hold_i,
  input wire logic halt_req_i,
  input wire logic clr_req_i,
  output logic halt_instr_o,
  output logic watchdog_clear_instruction_o
);
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      halt_instr_o <= 1'h0;
      watchdog_clear_instruction_o <= 1'h0;
    end else begin
      halt_instr_o <= halt_req_i && !cpu_hold_i;
      watchdog_clear_instruction_o <= clr_req_i && !cpu_hold_i;
    end
  end
endmodule

// File: bench/power_down_wakeup_watchdog_bench.sv
// Bench for the power-down, wake and watchdog block.
// Assumes the core model and the checker are compiled alongside.
`timescale 1ns/1ps
module power_down_wakeup_watchdog_bench;
  import pdw_pkg::*;
  localparam int WAKE = 16;
  logic clk_sys_i = 1'h0, sys_rst_i = 1'h1, rst_pin_n_i = 1'h1, wdt_osc_i = 1'h0, stack_full_i = 1'h0;
  logic halt_req = 1'h0, clr_req = 1'h0, osc_on = 1'h0, halt_instr_i, watchdog_clear_instruction_i;
  logic [23:0] pin_i = 24'hFFFFFF;
  logic [3:0] irq_req_i = 4'h0, irq_en_i = 4'h0;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
  logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic osc_run_o, cpu_hold_o, full_reset_o, wdt_reset_o, irq_service_o, usb_system_clock_rate_select_sel_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  int n_mismatch = 0, checked = 0, cyc = 0, ph = 0, n_full = 0, m = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  power_down_wakeup_watchdog #(.WAKE_CYC(WAKE)) dut (.clk_sys_i, .sys_rst_i, .rst_pin_n_i, .wdt_osc_i, .pin_i,
    .pin_wake_en_i(24'h000010), .irq_req_i, .irq_en_i, .stack_full_i, .halt_instr_i, .watchdog_clear_instruction_i,
    .clr_wdt1_i(1'h0), .clr_wdt2_i(1'h0), .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .osc_run_o, .cpu_hold_o, .full_reset_o, .wdt_reset_o, .irq_service_o, .usb_system_clock_rate_select_sel_o);
  core_model core (.clk_sys_i, .sys_rst_i, .cpu_hold_i(cpu_hold_o), .halt_req_i(halt_req), .clr_req_i(clr_req),
    .halt_instr_o(halt_instr_i), .watchdog_clear_instruction_o(watchdog_clear_instruction_i));
  // ----------------------------------------
  // Clocks, timeout, shared tasks
  // ----------------------------------------
  // Watchdog oscillator: six system clocks a period
  always @(posedge clk_sys_i) begin
    ph <= (ph == 2) ? 0 : ph + 1;
    if (osc_on && ph == 2) wdt_osc_i <= !wdt_osc_i;
    cyc <= cyc + 1;
    if (cyc == 9000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  always @(negedge clk_sys_i) if (full_reset_o === 1'h1) n_full++;
  task automatic give_verdict;
    $display("Mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ga, gw;
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    do begin
      @(negedge clk_sys_i);
      ga = s_axi_awready_o === 1'h1;
      gw = s_axi_wready_o === 1'h1;
      @(posedge clk_sys_i);
      if (ga) s_axi_awvalid_i <= 1'h0;
      if (gw) s_axi_wvalid_i <= 1'h0;
    end while (s_axi_awvalid_i || s_axi_wvalid_i);
    do @(negedge clk_sys_i); while (s_axi_bvalid_o !== 1'h1);
    chk(s_axi_bresp_o, r);
    @(posedge clk_sys_i);
    s_axi_bready_i <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    do @(negedge clk_sys_i); while (s_axi_arready_o !== 1'h1);
    @(posedge clk_sys_i);
    s_axi_arvalid_i <= 1'h0;
    do @(negedge clk_sys_i); while (s_axi_rvalid_o !== 1'h1);
    chk(s_axi_rdata_o, d);
    chk(s_axi_rresp_o, r);
    @(posedge clk_sys_i);
    s_axi_rready_i <= 1'h0;
  endtask
  task automatic halt_core;
    @(posedge clk_sys_i);
    halt_req <= 1'h1;
    @(posedge clk_sys_i);
    halt_req <= 1'h0;
    repeat (2) @(negedge clk_sys_i);
    chk(cpu_hold_o, 1'h1);
    chk(osc_run_o, 1'h0);
  endtask
  task automatic stays_down;
    repeat (30) @(negedge clk_sys_i);
    chk(osc_run_o, 1'h0);
  endtask
  // Waits for the wake, then times the restart delay
  task automatic wake_done(input logic w, input logic i, output int t);
    int n;
    n = 0;
    t = 0;
    do begin
      @(negedge clk_sys_i);
      t++;
    end while (osc_run_o !== 1'h1);
    while (cpu_hold_o === 1'h1) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk(n, WAKE);
    chk(wdt_reset_o, w);
    chk(irq_service_o, i);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(ADDR_PRESCALE, 32'h7, AXI_OKAY);
    rd(ADDR_CONFIG, 32'h1, AXI_OKAY);
    rd(ADDR_STATUS, 32'h0, AXI_OKAY);
    wr(ADDR_USB_CLK, 32'h1, AXI_OKAY);
    rd(ADDR_USB_CLK, 32'h1, AXI_OKAY);
    chk(usb_system_clock_rate_select_sel_o, 1'h1);
    wr(8'h10, 32'hF, AXI_SLVERR);
    rd(8'h10, 32'h0, AXI_SLVERR);
    wr(ADDR_PRESCALE, 32'hFD, AXI_OKAY);
    rd(ADDR_PRESCALE, 32'h5, AXI_OKAY);
  endtask
  task automatic t_pin;
    halt_core;
    @(posedge clk_sys_i);
    pin_i <= 24'hFFFFDF;
    stays_down;
    @(posedge clk_sys_i);
    pin_i <= 24'hFFFFCF;
    wake_done(1'h0, 1'h0, m);
    @(posedge clk_sys_i);
    pin_i <= 24'hFFFFFF;
    rd(ADDR_STATUS, 32'h1, AXI_OKAY);
  endtask
  task automatic t_irq;
    @(posedge clk_sys_i);
    irq_en_i <= 4'hF;
    irq_req_i <= 4'h1;
    halt_core;
    stays_down;
    @(posedge clk_sys_i);
    irq_req_i <= 4'h3;
    wake_done(1'h0, 1'h1, m);
    @(posedge clk_sys_i);
    stack_full_i <= 1'h1;
    halt_core;
    @(posedge clk_sys_i);
    irq_req_i <= 4'h7;
    wake_done(1'h0, 1'h0, m);
    @(posedge clk_sys_i);
    irq_req_i <= 4'h0;
    stack_full_i <= 1'h0;
    wr(ADDR_CONFIG, 32'h0, AXI_OKAY);
    clr_req <= 1'h1;
    @(posedge clk_sys_i);
    clr_req <= 1'h0;
    rd(ADDR_STATUS, 32'h1, AXI_OKAY);
    wr(ADDR_CONFIG, 32'h1, AXI_OKAY);
  endtask
  // Watchdog overflow after 256 oscillator ticks
  task automatic t_wdt_halt;
    int n;
    wr(ADDR_PRESCALE, 32'h0, AXI_OKAY);
    osc_on <= 1'h1;
    halt_core;
    wake_done(1'h1, 1'h0, n);
    chk(n > 1500 && n < 1570, 1'h1);
    osc_on <= 1'h0;
    rd(ADDR_STATUS, 32'h3, AXI_OKAY);
  endtask
  task automatic t_wdt_run;
    int n;
    wr(ADDR_CONFIG, 32'h3, AXI_OKAY);
    clr_req <= 1'h1;
    @(posedge clk_sys_i);
    clr_req <= 1'h0;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (full_reset_o !== 1'h1);
    chk(n > 1010 && n < 1040, 1'h1);
    rd(ADDR_STATUS, 32'h2, AXI_OKAY);
    wr(ADDR_CONFIG, 32'h1, AXI_OKAY);
  endtask
  task automatic t_rst_pin;
    halt_core;
    @(posedge clk_sys_i);
    rst_pin_n_i <= 1'h0;
    repeat (4) @(posedge clk_sys_i);
    rst_pin_n_i <= 1'h1;
    do @(negedge clk_sys_i); while (cpu_hold_o === 1'h1);
    chk(n_full, 2);
    rd(ADDR_STATUS, 32'h0, AXI_OKAY);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_i);
    sys_rst_i <= 1'h0;
    t_regs;
    t_pin;
    t_irq;
    t_wdt_halt;
    t_wdt_run;
    t_rst_pin;
    give_verdict;
  end
endmodule
